// file: verilog/crcsd_consts.svh
// Constants for the CRC engine with program-memory scanner.
// Assumes a 32-bit AHB-Lite slave port with each register in one aligned word.
//
// Functional notes
// - Watchdog runs regardless of scanner activity.
// - Debug halt freezes scanner until user mode.
// - Burst suspended by external halt, resumes after.
// - Halt during go-setting write delays the burst.
// - Burst halt lets current memory access finish.
// - Peek access waits until instruction really executes.
// - PC breakpoint: pending scan completes before entry.
// - Data breakpoint: scan requested then waits exit.
// - Single step: ready scan reads before re-entry.
// - Halt before scan cycle defers scan after exit.
// - Software breakpoint: stalling scan completes first.
// - Enable bit releases CRC from reset.
// - Start bit turns serial shifter on/off.
// - Busy reads 1 while shifting pending.
// - Accumulator mode selects zero augmentation.
// - Shift mode selects LSb or MSb first.
// - Full flag set until word enters shifter.
// - Data length minus one sets bits per word.
// - Poly length minus one sets accumulator width.
// - Low data byte write loads whole word.
// - Accumulator high byte reads/writes upper bits.
// - Scanner writes fetched words into data registers.
// - Scanner waits CRC ready before first load.
`ifndef CRCSD_CONSTS_SVH
`define CRCSD_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define CRCSD_OFF_CTRL0 8'h00
`define CRCSD_OFF_CTRL1 8'h04
`define CRCSD_OFF_DATH 8'h08
`define CRCSD_OFF_DATL 8'h0C
`define CRCSD_OFF_ACCH 8'h10
`define CRCSD_OFF_ACCL 8'h14
`define CRCSD_OFF_POLY 8'h18
`define CRCSD_OFF_SCTL 8'h1C
`define CRCSD_OFF_SLO 8'h20
`define CRCSD_OFF_SHI 8'h24

// ==========================================================
// Field positions
`define CRCSD_C0_EN 7
`define CRCSD_C0_START 6
`define CRCSD_C0_BUSY 5
`define CRCSD_C0_ZERO_AUGMENT_SELECT 4
`define CRCSD_C0_SHIFT 1
`define CRCSD_C0_FULL 0
`define CRCSD_SC_EN 7
`define CRCSD_SC_GO 6
`define CRCSD_SC_BUSY 5
`define CRCSD_SC_MODE_HI 1
`define CRCSD_SC_MODE_LO 0

// ==========================================================
// Reset values and encodings
`define CRCSD_RST_BYTE 8'h00
`define CRCSD_RST_WORD 16'h0000
`define CRCSD_MODE_CONC 2'h0
`define CRCSD_MODE_BURST 2'h1
`define CRCSD_MODE_PEEK 2'h2
`define CRCSD_MODE_TRIG 2'h3
`define CRCSD_HTRANS_NONSEQ_BIT 1
`define CRCSD_HRESP_OKAY 1'h0

`endif

// file: verilog/crcsd_pkg.sv
// Types shared by the CRC engine with program-memory scanner.
// Assumes nothing of its surroundings.
package crcsd_pkg;

  // ==========================================================
  // Scanner sequencer states
  typedef enum logic [2:0] {
    SCN_IDLE = 3'b001,
    SCN_RUN = 3'b010,
    SCN_FETCH = 3'b100
  } crcsd_scan_t;

endpackage

// file: verilog/crcsd_top.sv
// CRC engine with serial shifter, accumulator and program-memory scanner.
// Assumes a single-master AHB-Lite bus, a program memory port on hclk and
// debug status signals from the core on hclk.
`timescale 1ns/1ns
`include "crcsd_consts.svh"

module crcsd_top #(
  parameter int PM_LAST = 16'h0FFF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pm_req,
  output logic [15:0] pm_addr,
  input wire logic pm_ack,
  input wire logic [15:0] pm_rdata,
  input wire logic debug_mode,
  input wire logic ext_halt,
  input wire logic data_breakpoint,
  input wire logic cpu_idle_cycle,
  input wire logic scan_trigger_pin,
  output logic cpu_stall,
  output logic debug_entry_allow,
  output logic crc_busy,
  output logic scan_active
);

  // ==========================================================
  // Bus slave
  logic [7:0] addr_r;
  logic wr_r;
  logic rd_wait_r;
  logic [31:0] hrdata_r;
  logic take;
  logic wr_en;

  assign take = hsel & htrans[`CRCSD_HTRANS_NONSEQ_BIT] & hready;
  assign wr_en = wr_r;
  assign hreadyout = ~rd_wait_r;
  assign hresp = `CRCSD_HRESP_OKAY;
  assign hrdata = hrdata_r;

  // Reads take one wait state so that read data always comes from a flop
  // and already reflects a write that finished in the previous cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      rd_wait_r <= 1'b0;
    end else begin
      wr_r <= take & hwrite;
      rd_wait_r <= take & ~hwrite;
      if (take) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // ==========================================================
  // Control registers
  logic en_r;
  logic start_r;
  logic zero_augment_select_r;
  logic shift_dir_r;
  logic [3:0] data_length_minus_one_r;
  logic [3:0] poly_length_minus_one_r;
  logic [15:0] poly_r;
  logic [15:0] data_r;
  logic full_r;
  logic [15:0] acc_r;
  logic [15:0] shift_r;
  logic [4:0] cnt_r;
  logic scan_en_r;
  logic scan_go_r;
  logic [1:0] mode_r;
  logic [15:0] scan_addr_r;
  logic [15:0] scan_end_r;
  crcsd_pkg::crcsd_scan_t st_r;
  logic scan_load;
  logic scan_last;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
      start_r <= 1'b0;
      zero_augment_select_r <= 1'b0;
      shift_dir_r <= 1'b0;
      data_length_minus_one_r <= 4'h0;
      poly_length_minus_one_r <= 4'h0;
      poly_r <= `CRCSD_RST_WORD;
    end else if (wr_en) begin
      if (hit(addr_r, `CRCSD_OFF_CTRL0)) begin
        en_r <= hwdata[`CRCSD_C0_EN];
        start_r <= hwdata[`CRCSD_C0_START];
        zero_augment_select_r <= hwdata[`CRCSD_C0_ZERO_AUGMENT_SELECT];
        shift_dir_r <= hwdata[`CRCSD_C0_SHIFT];
      end
      if (hit(addr_r, `CRCSD_OFF_CTRL1)) begin
        data_length_minus_one_r <= hwdata[7:4];
        poly_length_minus_one_r <= hwdata[3:0];
      end
      if (hit(addr_r, `CRCSD_OFF_POLY)) begin
        poly_r <= hwdata[15:0];
      end
    end
  end

  // ==========================================================
  // Data registers and full flag
  logic sw_dath;
  logic sw_datl;
  logic shift_load;

  assign sw_dath = wr_en & hit(addr_r, `CRCSD_OFF_DATH) & ~full_r & ~pm_req;
  assign sw_datl = wr_en & hit(addr_r, `CRCSD_OFF_DATL) & ~full_r & ~pm_req & ~scan_load;
  assign shift_load = en_r & start_r & full_r & (cnt_r == 5'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= `CRCSD_RST_WORD;
    end else if (scan_load) begin
      data_r <= pm_rdata;
    end else begin
      if (sw_dath) begin
        data_r[15:8] <= hwdata[7:0];
      end
      if (sw_datl) begin
        data_r[7:0] <= hwdata[7:0];
      end
    end
  end

  // A word written while disabled is dropped: the unit is held in reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_r <= 1'b0;
    end else if (!en_r) begin
      full_r <= 1'b0;
    end else if (scan_load | sw_datl) begin
      full_r <= 1'b1;
    end else if (shift_load) begin
      full_r <= 1'b0;
    end
  end

  // ==========================================================
  // Shifter and accumulator
  logic in_bit;
  logic [15:0] acc_step;

  function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic b,
                                           input logic [3:0] poly_length_minus_one, input logic [15:0] poly,
                                           input logic aug, input logic right);
    logic [15:0] msk;
    logic [15:0] nxt;
    logic fb;
    msk = 16'hFFFF >> (4'hF - poly_length_minus_one);
    if (right) begin
      fb = aug ? acc[0] : (acc[0] ^ b);
      nxt = acc >> 1;
      if (aug) begin
        nxt = nxt | ({15'h0000, b} << poly_length_minus_one);
      end
    end else begin
      fb = aug ? acc[poly_length_minus_one] : (acc[poly_length_minus_one] ^ b);
      nxt = {acc[14:0], aug & b};
    end
    if (fb) begin
      nxt = nxt ^ poly;
    end
    crc_step = nxt & msk;
  endfunction

  assign in_bit = shift_dir_r ? shift_r[0] : shift_r[data_length_minus_one_r];
  assign acc_step = crc_step(acc_r, in_bit, poly_length_minus_one_r, poly_r, zero_augment_select_r, shift_dir_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= `CRCSD_RST_WORD;
      cnt_r <= 5'h00;
    end else if (!en_r) begin
      shift_r <= `CRCSD_RST_WORD;
      cnt_r <= 5'h00;
    end else if (shift_load) begin
      shift_r <= data_r;
      cnt_r <= {1'b0, data_length_minus_one_r} + 5'h01;
    end else if (start_r && cnt_r != 5'h00) begin
      shift_r <= shift_dir_r ? (shift_r >> 1) : (shift_r << 1);
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // A software write to the accumulator wins over a shift in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= `CRCSD_RST_WORD;
    end else if (wr_en && hit(addr_r, `CRCSD_OFF_ACCH)) begin
      acc_r[15:8] <= hwdata[7:0];
    end else if (wr_en && hit(addr_r, `CRCSD_OFF_ACCL)) begin
      acc_r[7:0] <= hwdata[7:0];
    end else if (en_r && start_r && cnt_r != 5'h00) begin
      acc_r <= acc_step;
    end
  end

  assign crc_busy = full_r | (cnt_r != 5'h00);

  // ==========================================================
  // Trigger pin synchroniser
  logic [2:0] trig_s_r;
  logic trig_lvl_r;
  logic trig_rise;

  // Three stages; a change counts only once stages two and three agree.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_s_r <= 3'h0;
      trig_lvl_r <= 1'b0;
    end else begin
      trig_s_r <= {trig_s_r[1:0], scan_trigger_pin};
      if (trig_s_r[1] == trig_s_r[2]) begin
        trig_lvl_r <= trig_s_r[2];
      end
    end
  end

  assign trig_rise = (trig_s_r[1] == trig_s_r[2]) & trig_s_r[2] & ~trig_lvl_r;

  // ==========================================================
  // Scanner sequencer
  logic trig_seen_r;
  logic crc_ready;
  logic may_start;
  logic start_fetch;
  logic sw_go_set;
  logic burst;

  assign burst = (mode_r == `CRCSD_MODE_BURST);
  assign crc_ready = en_r & start_r & ~full_r;
  assign sw_go_set = wr_en & hit(addr_r, `CRCSD_OFF_SCTL) & hwdata[`CRCSD_SC_GO];

  // A new access never starts in a debug cycle, a halt cycle or a data
  // breakpoint cycle; an access already under way runs to its end unless scan enable is cleared.
  always_comb begin
    may_start = crc_ready & ~debug_mode & ~ext_halt & ~data_breakpoint;
    unique case (mode_r)
      `CRCSD_MODE_PEEK: may_start = may_start & cpu_idle_cycle;
      `CRCSD_MODE_TRIG: may_start = may_start & (trig_seen_r | trig_rise);
      default: may_start = may_start;
    endcase
  end

  assign start_fetch = (st_r == crcsd_pkg::SCN_RUN) & scan_go_r & may_start;
  assign scan_load = (st_r == crcsd_pkg::SCN_FETCH) & pm_ack;
  assign scan_last = (scan_addr_r >= scan_end_r) | (scan_addr_r == 16'(PM_LAST));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= crcsd_pkg::SCN_IDLE;
    end else if (!scan_en_r) begin
      st_r <= crcsd_pkg::SCN_IDLE;
    end else begin
      unique case (st_r)
        crcsd_pkg::SCN_IDLE: begin
          if (scan_go_r) begin
            st_r <= crcsd_pkg::SCN_RUN;
          end
        end
        crcsd_pkg::SCN_RUN: begin
          if (!scan_go_r) begin
            st_r <= crcsd_pkg::SCN_IDLE;
          end else if (start_fetch) begin
            st_r <= crcsd_pkg::SCN_FETCH;
          end
        end
        crcsd_pkg::SCN_FETCH: begin
          if (pm_ack) begin
            st_r <= crcsd_pkg::SCN_RUN;
          end
        end
        default: st_r <= crcsd_pkg::SCN_IDLE;
      endcase
    end
  end

  // The trigger is armed by go and remembered until the scan ends.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_seen_r <= 1'b0;
    end else if (!scan_go_r || !scan_en_r) begin
      trig_seen_r <= 1'b0;
    end else if (trig_rise) begin
      trig_seen_r <= 1'b1;
    end
  end

  // Go is set by software and cleared by software, at the end address or at PM_LAST;
  // a software set in the same cycle as the hardware clear wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_en_r <= 1'b0;
      scan_go_r <= 1'b0;
      mode_r <= `CRCSD_MODE_CONC;
      scan_addr_r <= `CRCSD_RST_WORD;
      scan_end_r <= `CRCSD_RST_WORD;
    end else begin
      if (wr_en && hit(addr_r, `CRCSD_OFF_SCTL)) begin
        scan_en_r <= hwdata[`CRCSD_SC_EN];
        scan_go_r <= hwdata[`CRCSD_SC_GO];
        mode_r <= hwdata[`CRCSD_SC_MODE_HI:`CRCSD_SC_MODE_LO];
      end else if (scan_load && scan_last) begin
        scan_go_r <= 1'b0;
      end
      if (wr_en && hit(addr_r, `CRCSD_OFF_SLO) && !scan_go_r) begin
        scan_addr_r <= hwdata[15:0];
      end else if (scan_load) begin
        scan_addr_r <= scan_addr_r + 16'h0001;
      end
      if (wr_en && hit(addr_r, `CRCSD_OFF_SHI) && !scan_go_r) begin
        scan_end_r <= hwdata[15:0];
      end
    end
  end

  assign pm_req = (st_r == crcsd_pkg::SCN_FETCH);
  assign pm_addr = scan_addr_r;
  assign scan_active = scan_go_r & scan_en_r;

  // Debug entry is held off while an access is in flight or about to start,
  // so breakpoint, step and software-break entries follow the scan cycle.
  assign debug_entry_allow = ~pm_req & ~start_fetch;

  // Burst holds the CPU from the cycle after go is set, except while the
  // debugger owns it. Nothing here touches the watchdog, so long bursts can
  // still time it out; software must budget for that.
  assign cpu_stall = (scan_active & burst & ~debug_mode & ~sw_go_set)
                     | (pm_req & ~burst & (mode_r != `CRCSD_MODE_PEEK));

  // ==========================================================
  // Read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata_r <= 32'h0000_0000;
      unique case (addr_r)
        `CRCSD_OFF_CTRL0: hrdata_r[7:0] <= {en_r, start_r, crc_busy, zero_augment_select_r,
                                             2'b00, shift_dir_r, full_r};
        `CRCSD_OFF_CTRL1: hrdata_r[7:0] <= {data_length_minus_one_r, poly_length_minus_one_r};
        `CRCSD_OFF_DATH: hrdata_r[7:0] <= data_r[15:8];
        `CRCSD_OFF_DATL: hrdata_r[7:0] <= data_r[7:0];
        `CRCSD_OFF_ACCH: hrdata_r[7:0] <= acc_r[15:8];
        `CRCSD_OFF_ACCL: hrdata_r[7:0] <= acc_r[7:0];
        `CRCSD_OFF_POLY: hrdata_r[15:0] <= poly_r;
        `CRCSD_OFF_SCTL: hrdata_r[7:0] <= {scan_en_r, scan_go_r, pm_req, 3'b000, mode_r};
        `CRCSD_OFF_SLO: hrdata_r[15:0] <= scan_addr_r;
        `CRCSD_OFF_SHI: hrdata_r[15:0] <= scan_end_r;
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// file: sim/crcsd_asserts.sv
// Port checker for the CRC engine with program-memory scanner.
// Assumes it is bound to crcsd_top and sees only its ports.
`timescale 1ns/1ns
module crcsd_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic pm_req,
  input wire logic [15:0] pm_addr,
  input wire logic pm_ack,
  input wire logic debug_mode,
  input wire logic ext_halt,
  input wire logic data_breakpoint,
  input wire logic debug_entry_allow,
  input wire logic crc_busy,
  input wire logic scan_active
);
  // ==========================================================
  // Shared terms
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic take;
  assign take = hsel & htrans[1] & hready;
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_word_taken;
    pm_req && pm_ack;
  endsequence
  // ==========================================================
  // Bus and scanner relations
  a_read_wait: assert property (take && !hwrite |=> s_one_wait)
    else $error("read wait state wrong");
  a_write_fast: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_fetch_hold: assert property (pm_req && !pm_ack |=> pm_req && $stable(pm_addr))
    else $error("fetch dropped or address moved");
  a_fetch_next: assert property (s_word_taken |=> !pm_req && pm_addr == $past(pm_addr) + 16'h0001)
    else $error("address not advanced");
  a_halt_nofetch: assert property ($rose(pm_req) |-> $past(!debug_mode && !ext_halt && !data_breakpoint))
    else $error("fetch started in debug or halt");
  a_entry_block: assert property (pm_req |-> !debug_entry_allow)
    else $error("debug entry allowed in fetch");
  a_word_full: assert property (s_word_taken |=> crc_busy)
    else $error("fetched word not pending");
  a_fetch_active: assert property (pm_req |-> scan_active)
    else $error("fetch without scan");
endmodule

bind crcsd_top crcsd_asserts u_crcsd_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .pm_req(pm_req),
  .pm_addr(pm_addr), .pm_ack(pm_ack), .debug_mode(debug_mode), .ext_halt(ext_halt),
  .data_breakpoint(data_breakpoint), .debug_entry_allow(debug_entry_allow),
  .crc_busy(crc_busy), .scan_active(scan_active));

// file: sim/crcsd_pm_model.sv
// Program memory partner: answers each fetch after 0 to 3 cycles.
// Assumes pm_req and pm_addr hold until the cycle of pm_ack.
`timescale 1ns/1ns
module crcsd_pm_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pm_req,
  input wire logic [15:0] pm_addr,
  output logic pm_ack,
  output logic [15:0] pm_rdata
);
  logic [3:0] lf_r;
  logic [1:0] cnt_r;
  // ==========================================================
  // Fetch answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lf_r <= 4'h9;
      cnt_r <= 2'h0;
      pm_ack <= 1'b0;
      pm_rdata <= 16'h0000;
    end else begin
      lf_r <= {lf_r[2:0], lf_r[3] ^ lf_r[2]};
      if (pm_req && !pm_ack && cnt_r >= lf_r[1:0]) begin
        pm_ack <= 1'b1;
        pm_rdata <= pm_addr ^ 16'h5A3C;
        cnt_r <= 2'h0;
      end else begin
        // Data toggles outside an answer so a stale word is never taken.
        pm_ack <= 1'b0;
        pm_rdata <= ~pm_rdata;
        if (pm_req) begin
          cnt_r <= cnt_r + 2'h1;
        end
      end
    end
  end
endmodule

// file: sim/crc_engine_scanner_debug_tb.sv
// Self-checking bench for the CRC engine with program-memory scanner.
// Assumes crcsd_top, crcsd_pm_model and the bound checker.
`timescale 1ns/1ns
`include "crcsd_consts.svh"
module crc_engine_scanner_debug_tb;
  logic hclk, hresetn, hsel, hwrite, pm_ack, pm_req, debug_mode, ext_halt;
  logic data_breakpoint, cpu_idle_cycle, scan_trigger_pin, hreadyout, hresp;
  logic cpu_stall, debug_entry_allow, crc_busy, scan_active, hready, seen, ag, rt, stl;
  logic [31:0] haddr, hwdata, hrdata, rd, s1, s2;
  logic [15:0] pm_addr, pm_rdata, d, p, ex, a0;
  logic [7:0] c;
  logic [3:0] dl;
  logic [1:0] htrans;
  int fails, checked;
  assign hready = hreadyout;
  crcsd_top u_crcsd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_ack(pm_ack), .pm_rdata(pm_rdata), .debug_mode(debug_mode), .ext_halt(ext_halt),
    .data_breakpoint(data_breakpoint), .cpu_idle_cycle(cpu_idle_cycle),
    .scan_trigger_pin(scan_trigger_pin), .cpu_stall(cpu_stall),
    .debug_entry_allow(debug_entry_allow), .crc_busy(crc_busy), .scan_active(scan_active));
  crcsd_pm_model u_crcsd_pm_model (.hclk(hclk), .hresetn(hresetn), .pm_req(pm_req),
    .pm_addr(pm_addr), .pm_ack(pm_ack), .pm_rdata(pm_rdata));
  // ==========================================================
  // Clock, random core status and helpers
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Halts and breakpoints arrive at random so scans are cut at every phase.
  always @(posedge hclk) begin
    s2 = xs(s2);
    debug_mode <= s2[7:4] == 4'h0;
    ext_halt <= s2[11:8] == 4'h0;
    data_breakpoint <= s2[15:12] == 4'h0;
    cpu_idle_cycle <= s2[0];
    scan_trigger_pin <= s2[1];
  end
  // Reference fold with a 16-bit polynomial length.
  function automatic logic [15:0] crc(input logic [15:0] a, input logic [15:0] w,
    input logic [3:0] n, input logic [15:0] q, input logic g, input logic r);
    logic b;
    logic f;
    for (int i = 0; i <= int'(n); i++) begin
      b = r ? w[i] : w[int'(n) - i];
      f = (r ? a[0] : a[15]) ^ (b & !g);
      a = r ? {g & b, a[15:1]} : {a[14:0], g & b};
      if (f) a = a ^ q;
    end
    return a;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) fails++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    xfer(1'b1, a, {16'h0, v});
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, {16'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; stl |= cpu_stall; end
    while ((crc_busy | scan_active) !== 1'b0 && n < 3000);
    if (n >= 3000) fails++;
  endtask
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, debug_mode, ext_halt} = '0;
    {data_breakpoint, cpu_idle_cycle, scan_trigger_pin, fails, checked} = '0;
    s1 = 32'd72516;
    s2 = 32'd72516;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(`CRCSD_OFF_CTRL0, 16'h0000);
    rc(`CRCSD_OFF_CTRL1, 16'h0000);
    rc(`CRCSD_OFF_ACCH, 16'h0000);
    rc(8'h30, 16'h0000);
    wr(`CRCSD_OFF_CTRL0, 16'h00FF);
    rc(`CRCSD_OFF_CTRL0, 16'h00D2);
    for (int k = 0; k < 4; k++) begin
      s1 = xs(s1);
      {p, d} = s1 & 32'hFFFE_FFFF;
      {rt, ag} = k[1:0];
      dl = ag ? 4'h7 : 4'hF;
      c = {3'b100, ag, 2'b00, rt, 1'b0};
      wr(`CRCSD_OFF_CTRL1, {8'h0, dl, p[11:8]});
      rc(`CRCSD_OFF_CTRL1, {8'h0, dl, p[11:8]});
      wr(`CRCSD_OFF_CTRL1, {8'h0, dl, 4'hF});
      wr(`CRCSD_OFF_POLY, p);
      wr(`CRCSD_OFF_ACCH, {8'h0, p[7:0]});
      rc(`CRCSD_OFF_ACCH, {8'h0, p[7:0]});
      wr(`CRCSD_OFF_ACCH, 16'h0000);
      wr(`CRCSD_OFF_ACCL, 16'h0000);
      wr(`CRCSD_OFF_CTRL0, {8'h0, c});
      wr(`CRCSD_OFF_DATH, {8'h0, d[15:8]});
      wr(`CRCSD_OFF_DATL, {8'h0, d[7:0]});
      rc(`CRCSD_OFF_CTRL0, {8'h0, c | 8'h21});
      wr(`CRCSD_OFF_DATL, {8'h0, ~d[7:0]});
      wr(`CRCSD_OFF_CTRL0, {8'h0, c | 8'h40});
      wait_idle();
      ex = crc(16'h0000, d, dl, p, ag, rt);
      rc(`CRCSD_OFF_ACCH, {8'h0, ex[15:8]});
      rc(`CRCSD_OFF_ACCL, {8'h0, ex[7:0]});
    end
    for (int m = 0; m < 4; m++) begin
      a0 = 16'h0010 + 16'(m * 8);
      wr(`CRCSD_OFF_CTRL1, 16'h00FF);
      wr(`CRCSD_OFF_ACCH, 16'h0000);
      wr(`CRCSD_OFF_ACCL, 16'h0000);
      wr(`CRCSD_OFF_CTRL0, m == 0 ? 16'h0080 : 16'h00C0);
      wr(`CRCSD_OFF_SLO, a0);
      wr(`CRCSD_OFF_SHI, a0 + 16'h0003);
      stl = 1'b0;
      wr(`CRCSD_OFF_SCTL, 16'h00C0 | 16'(m));
      if (m == 0) begin
        seen = 1'b0;
        repeat (20) @(posedge hclk) seen |= pm_req;
        chk({31'h0, seen}, 32'h0);
        wr(`CRCSD_OFF_CTRL0, 16'h00C0);
      end
      wait_idle();
      chk({31'h0, stl}, {31'h0, m != 2});
      ex = 16'h0000;
      for (int j = 0; j < 4; j++) ex = crc(ex, (a0 + 16'(j)) ^ 16'h5A3C, 4'hF, p, 1'b0, 1'b0);
      rc(`CRCSD_OFF_ACCH, {8'h0, ex[15:8]});
      rc(`CRCSD_OFF_ACCL, {8'h0, ex[7:0]});
    end
    stop_test();
  end
endmodule
